// ==== core/rps_edge_det.sv ====
// Selectable edge detector for the external interrupt input
`timescale 1ns/1ps
`default_nettype none
module rps_edge_det
    import rps_pkg::*;
(
    input wire logic mclk,             // Core clock
    input wire logic reset,            // Asynchronous reset, active high
    input wire logic level,            // Synchronised input level
    input wire logic arm,              // Detection allowed
    input wire logic [1:0] edge_sel,   // Edge code
    output logic hit                   // One-cycle pulse on a selected edge
);
    logic prev_level;
    wire rose = level & ~prev_level;
    wire fell = ~level & prev_level;
    logic next_hit;

    // Reserved code picks no edge
    always_comb begin
        unique case (edge_sel)
            EDGE_RISE: next_hit = rose;
            EDGE_FALL: next_hit = fell;
            EDGE_BOTH: next_hit = rose | fell;
            EDGE_RESERVED: next_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prev_level <= 1'b0;
            hit <= 1'b0;
        end else begin
            prev_level <= level;
            hit <= next_hit & arm;
        end
    end
endmodule // rps_edge_det
`default_nettype wire

// ==== core/rps_sfr_bank.sv ====
// Upper special function register slice with Wishbone slave and interrupt flags
// Summary of operation
// - Six wake enables, bits 5:0, reset ones
// - Three-bit PC high buffer, reset zero
// - Pull-down enables bits 7:4, active low, reset ones
// - Pull-up enables bits 5:0, active low, reset ones
// - Six interrupt enables at fixed bits, reset zero
// - Events set matching flags, same bit layout
// - Flags stay set until firmware writes clear
// - Flag reads masked by enable bits
// - Two-bit edge select, 00 reserved, reset 01
// - Edge register bit 4 makes pin zero interrupt
// - Timer bits write reload, read running count
// - PWM1 and PWM2 upper duty bits stored
// - Comparator enable bit 7, reset zero
// - PWM3 upper duty bits stored
// - PC high bits load only from buffer
// - Global enable gates every interrupt request
`timescale 1ns/1ps
`default_nettype none
module rps_sfr_bank
    import rps_pkg::*;
(
    input wire logic mclk,                     // Core clock, 50 MHz
    input wire logic reset,                    // Asynchronous reset, active high
    input wire logic wb_cyc_i,                 // Wishbone cycle
    input wire logic wb_stb_i,                 // Wishbone strobe
    input wire logic wb_we_i,                  // Wishbone write
    input wire logic [7:0] wb_adr_i,           // Wishbone byte address
    input wire logic [3:0] wb_sel_i,           // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,          // Wishbone write data
    output logic [31:0] wb_dat_o,              // Wishbone read data
    output logic wb_ack_o,                     // Wishbone acknowledge
    input wire logic [5:0] port_pins,          // Port pin levels, asynchronous
    input wire rps_events_t events,            // Event pulses from peripherals
    input wire logic [9:0] timer1_count,       // Running Timer1 count
    input wire logic pc_load,                  // Core loads PC high bits
    output logic irq,                          // Interrupt request, level
    output logic [5:0] pin_wake_enable,        // Per-pin wake enables
    output logic [3:0] pull_low_enable_n,      // Pull-down enables, active low
    output logic [5:0] pull_high_enable_n,     // Pull-up enables, active low
    output logic [2:0] pc_high,                // PC bits 10:8
    output logic ext_pin_role_select,          // Pin zero is interrupt input
    output logic [1:0] timer1_upper_bits,      // Timer1 reload bits 9:8
    output logic timer1_reload_write,          // Pulse when reload bits written
    output logic [1:0] pwm1_duty_upper,        // PWM1 duty bits 9:8
    output logic [1:0] pwm2_duty_upper,        // PWM2 duty bits 9:8
    output logic [1:0] pwm3_duty_upper,        // PWM3 duty bits 9:8
    output logic comparator_enable             // Voltage comparator on
);

    rps_bus_state_t bus_state;
    logic [2:0] pc_high_buffer_bits;
    logic [7:0] int_enable;
    logic [7:0] int_flags;
    logic [1:0] ext_edge_select;
    logic global_irq_enable;
    logic [5:0] pins_sync;
    logic [5:0] pins_prev;
    logic ext_hit;

    // Bus decode
    wire req = wb_cyc_i & wb_stb_i & (bus_state == BUS_IDLE);
    wire [4:0] idx = wb_adr_i[6:2];
    wire aligned = (wb_adr_i[1:0] == 2'h0) & ~wb_adr_i[7];
    wire wr = req & wb_we_i & wb_sel_i[0] & aligned;
    wire rd = req & ~wb_we_i;
    wire [7:0] wdat = wb_dat_i[7:0];
    wire wr_wake = wr & (idx == IDX_WAKE);
    wire wr_pchb = wr & (idx == IDX_PCHB);
    wire wr_pull_low = wr & (idx == IDX_PULL_LOW);
    wire wr_pull_high = wr & (idx == IDX_PULL_HIGH);
    wire wr_int_en = wr & (idx == IDX_INT_EN);
    wire wr_flags = wr & (idx == IDX_INT_FLAGS);
    wire wr_edge = wr & (idx == IDX_EDGE);
    wire wr_tmr_high = wr & (idx == IDX_TMR_HIGH);
    wire wr_analog = wr & (idx == IDX_ANALOG);
    wire wr_pwm3 = wr & (idx == IDX_PWM3_HIGH);
    wire wr_irq_ctrl = wr & (idx == IDX_IRQ_CTRL);

    // Pin levels cross into the core clock before anyone looks at them
    rps_sync2 #(
        .WIDTH(6)
    ) u_pin_sync (
        .mclk(mclk),
        .reset(reset),
        .async(port_pins),
        .synced(pins_sync)
    );

    // External interrupt edge on pin zero, only while the pin has that role
    rps_edge_det u_ext_edge (
        .mclk(mclk),
        .reset(reset),
        .level(pins_sync[0]),
        .arm(ext_pin_role_select),
        .edge_sel(ext_edge_select),
        .hit(ext_hit)
    );

    // Port change counts only on pins whose wake enable is set
    wire port_change = |((pins_sync ^ pins_prev) & pin_wake_enable);

    // Event vector in flag layout
    wire [7:0] set_vec = 8'((1 << BIT_T0) & {8{events.timer0_overflow}})
        | 8'((1 << BIT_PORT) & {8{port_change}})
        | 8'((1 << BIT_EXT) & {8{ext_hit}})
        | 8'((1 << BIT_T1) & {8{events.timer1_underflow}})
        | 8'((1 << BIT_LVD) & {8{events.low_voltage}})
        | 8'((1 << BIT_WDT) & {8{events.watchdog_timeout}});

    // Writing zero clears a flag; writing one leaves it alone
    wire [7:0] clr_vec = wr_flags ? (~wdat & MASK_INT) : 8'h00;
    // A set arriving with a clear wins so no event is lost
    wire [7:0] next_flags = ((int_flags & ~clr_vec) | set_vec) & MASK_INT;

    // Read data, unimplemented bits read zero
    logic [7:0] rbyte;
    always_comb begin
        rbyte = 8'h00;
        if (aligned) begin
            unique case (idx)
                IDX_WAKE: rbyte = {2'h0, pin_wake_enable};
                IDX_PCHB: rbyte = {5'h00, pc_high_buffer_bits};
                IDX_PULL_LOW: rbyte = {pull_low_enable_n, 4'h0};
                IDX_PULL_HIGH: rbyte = {2'h0, pull_high_enable_n};
                IDX_INT_EN: rbyte = int_enable;
                IDX_INT_FLAGS: rbyte = int_flags & int_enable;
                IDX_EDGE: rbyte = {3'h0, ext_pin_role_select, 2'h0, ext_edge_select};
                IDX_TMR_HIGH: rbyte = {2'h0, timer1_count[9:8], pwm2_duty_upper,
                    pwm1_duty_upper};
                IDX_ANALOG: rbyte = {comparator_enable, 7'h00};
                IDX_PWM3_HIGH: rbyte = {6'h00, pwm3_duty_upper};
                IDX_IRQ_CTRL: rbyte = {7'h00, global_irq_enable};
                default: rbyte = 8'h00;
            endcase
        end
    end

    // Bus slave: one wait cycle, then a single-cycle ack; unmapped gives zero
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_state <= BUS_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            bus_state <= req ? BUS_ACK : BUS_IDLE;
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= {24'h00_0000, rbyte};
            end
        end
    end

    // Port configuration registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_wake_enable <= RST_WAKE;
            pull_low_enable_n <= RST_PULL_LOW;
            pull_high_enable_n <= RST_PULL_HIGH;
            pc_high_buffer_bits <= RST_PCHB;
        end else begin
            if (wr_wake) begin
                pin_wake_enable <= wdat[5:0];
            end
            if (wr_pull_low) begin
                pull_low_enable_n <= wdat[PULL_LOW_LSB +: 4];
            end
            if (wr_pull_high) begin
                pull_high_enable_n <= wdat[5:0];
            end
            if (wr_pchb) begin
                pc_high_buffer_bits <= wdat[2:0];
            end
        end
    end

    // PC high bits move only when the core loads them from the buffer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pc_high <= RST_PCHB;
        end else if (pc_load) begin
            pc_high <= pc_high_buffer_bits;
        end
    end

    // Interrupt enable, flags and global enable
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            int_enable <= RST_INT_EN;
            int_flags <= RST_FLAGS;
            global_irq_enable <= RST_GIE;
            pins_prev <= 6'h00;
        end else begin
            if (wr_int_en) begin
                int_enable <= wdat & MASK_INT;
            end
            int_flags <= next_flags;
            if (wr_irq_ctrl) begin
                global_irq_enable <= wdat[GIE_BIT];
            end
            pins_prev <= pins_sync;
        end
    end

    // Any flag that software has enabled
    wire irq_pending = |(int_flags & int_enable);

    // Request is a registered level so the core sees a clean signal
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= global_irq_enable & irq_pending;
        end
    end

    // Edge, timer, PWM and analog control
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ext_edge_select <= RST_EDGE_SEL;
            ext_pin_role_select <= RST_ROLE;
            timer1_upper_bits <= RST_DUTY;
            timer1_reload_write <= 1'b0;
            pwm1_duty_upper <= RST_DUTY;
            pwm2_duty_upper <= RST_DUTY;
            pwm3_duty_upper <= RST_DUTY;
            comparator_enable <= RST_CMP;
        end else begin
            timer1_reload_write <= wr_tmr_high;
            if (wr_edge) begin
                ext_edge_select <= wdat[1:0];
                ext_pin_role_select <= wdat[EDGE_ROLE_BIT];
            end
            if (wr_tmr_high) begin
                timer1_upper_bits <= wdat[TMR1_LSB +: 2];
                pwm1_duty_upper <= wdat[1:0];
                pwm2_duty_upper <= wdat[PWM2_LSB +: 2];
            end
            if (wr_pwm3) begin
                pwm3_duty_upper <= wdat[1:0];
            end
            if (wr_analog) begin
                comparator_enable <= wdat[CMP_BIT];
            end
        end
    end

    // Checks on the behaviour above
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");

    a_flag_sticky: assert property (int_flags[BIT_T0] && !wr_flags |=> int_flags[BIT_T0])
        else $error("flag cleared without a write");

    a_event_sets: assert property (events.timer1_underflow |=> int_flags[BIT_T1])
        else $error("underflow did not set its flag");

    a_ext_sets: assert property (ext_hit |=> int_flags[BIT_EXT])
        else $error("external edge did not set its flag");

    a_read_masked: assert property (wb_ack_o && !$past(wb_we_i) && $past(idx) == IDX_INT_FLAGS
        |-> (wb_dat_o[7:0] & ~$past(int_enable)) == 8'h00)
        else $error("disabled flag visible on read");

    a_global_gate: assert property (!global_irq_enable[*2] |-> ##1 !irq)
        else $error("request raised while globally disabled");

    a_irq_cause: assert property ($rose(irq) |-> $past(irq_pending))
        else $error("request without an enabled flag");

    a_pc_from_buf: assert property ($changed(pc_high) |-> $past(pc_load)
        && pc_high == $past(pc_high_buffer_bits))
        else $error("pc high changed without a load");

    a_wake_write: assert property (wr_wake
        |=> {2'h0, pin_wake_enable} == ($past(wdat) & 8'h3f))
        else $error("wake enables not written");

    a_edge_reserved: assert property (ext_edge_select == EDGE_RESERVED |=> !ext_hit)
        else $error("edge fired on reserved code");

    a_role_gate: assert property (!ext_pin_role_select |=> !ext_hit)
        else $error("edge fired while pin is general purpose");

    a_pchb_write: assert property (wr_pchb
        |=> {5'h00, pc_high_buffer_bits} == ($past(wdat) & 8'h07))
        else $error("pc buffer not written");

    a_pull_low_write: assert property (wr_pull_low
        |=> {pull_low_enable_n, 4'h0} == ($past(wdat) & 8'hf0))
        else $error("pull-down enables not written");

    a_pull_high_write: assert property (wr_pull_high
        |=> {2'h0, pull_high_enable_n} == ($past(wdat) & 8'h3f))
        else $error("pull-up enables not written");

    a_enable_write: assert property (wr_int_en
        |=> int_enable == ($past(wdat) & MASK_INT))
        else $error("interrupt enables not written");

    a_t0_sets: assert property (events.timer0_overflow |=> int_flags[BIT_T0])
        else $error("overflow did not set its flag");

    a_lvd_sets: assert property (events.low_voltage |=> int_flags[BIT_LVD])
        else $error("low voltage did not set its flag");

    a_wdt_sets: assert property (events.watchdog_timeout |=> int_flags[BIT_WDT])
        else $error("watchdog did not set its flag");

    a_port_sets: assert property (port_change |=> int_flags[BIT_PORT])
        else $error("pin change did not set its flag");

    a_flag_clear: assert property (wr_flags && !wdat[BIT_T1] && !set_vec[BIT_T1]
        |=> !int_flags[BIT_T1])
        else $error("written zero did not clear flag");

    a_edge_write: assert property (wr_edge
        |=> {3'h0, ext_pin_role_select, 2'h0, ext_edge_select} == ($past(wdat) & 8'h13))
        else $error("edge register not written");

    a_tmr_write: assert property (wr_tmr_high
        |=> {2'h0, timer1_upper_bits, pwm2_duty_upper, pwm1_duty_upper} == ($past(wdat) & 8'h3f))
        else $error("timer high register not written");

    a_reload_pulse: assert property (wr_tmr_high |=> timer1_reload_write)
        else $error("reload pulse missing");

    a_pwm3_write: assert property (wr_pwm3
        |=> {6'h00, pwm3_duty_upper} == ($past(wdat) & 8'h03))
        else $error("pwm3 duty bits not written");

    a_cmp_write: assert property (wr_analog
        |=> {comparator_enable, 7'h00} == ($past(wdat) & 8'h80))
        else $error("comparator enable not written");

    a_irq_raise: assert property (global_irq_enable && irq_pending |=> irq)
        else $error("enabled flag raised no request");

endmodule // rps_sfr_bank
`default_nettype wire

// ==== core/rps_sync2.sv ====
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module rps_sync2 #(
    parameter int WIDTH = 6
) (
    input wire logic mclk,               // Core clock
    input wire logic reset,              // Asynchronous reset, active high
    input wire logic [WIDTH-1:0] async,  // Levels from the pins
    output logic [WIDTH-1:0] synced      // Levels safe to use in the mclk domain
);
    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stage_one <= '0;
            synced <= '0;
        end else begin
            stage_one <= async;
            synced <= stage_one;
        end
    end
endmodule // rps_sync2
`default_nettype wire

// ==== shared/rps_pkg.sv ====
// Constants, codes and carrier types for the upper special function register slice
package rps_pkg;

    // Register indexes; the byte address on the bus is four times the index
    localparam logic [4:0] IDX_WAKE = 5'h09;
    localparam logic [4:0] IDX_PCHB = 5'h0a;
    localparam logic [4:0] IDX_PULL_LOW = 5'h0b;
    localparam logic [4:0] IDX_PULL_HIGH = 5'h0c;
    localparam logic [4:0] IDX_INT_EN = 5'h0e;
    localparam logic [4:0] IDX_INT_FLAGS = 5'h0f;
    localparam logic [4:0] IDX_EDGE = 5'h18;
    localparam logic [4:0] IDX_TMR_HIGH = 5'h19;
    localparam logic [4:0] IDX_ANALOG = 5'h1a;
    localparam logic [4:0] IDX_PWM3_HIGH = 5'h1c;
    localparam logic [4:0] IDX_IRQ_CTRL = 5'h1e;

    // Implemented bits of the interrupt enable and flag registers
    localparam logic [7:0] MASK_INT = 8'h5f;

    // Field positions
    localparam int BIT_T0 = 0;
    localparam int BIT_PORT = 1;
    localparam int BIT_EXT = 2;
    localparam int BIT_T1 = 3;
    localparam int BIT_LVD = 4;
    localparam int BIT_WDT = 6;
    localparam int EDGE_ROLE_BIT = 4;
    localparam int TMR1_LSB = 4;
    localparam int PWM2_LSB = 2;
    localparam int PULL_LOW_LSB = 4;
    localparam int CMP_BIT = 7;
    localparam int GIE_BIT = 0;

    // Reset values
    localparam logic [5:0] RST_WAKE = 6'h3f;
    localparam logic [2:0] RST_PCHB = 3'h0;
    localparam logic [3:0] RST_PULL_LOW = 4'hf;
    localparam logic [5:0] RST_PULL_HIGH = 6'h3f;
    localparam logic [7:0] RST_INT_EN = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [1:0] RST_EDGE_SEL = 2'h1;
    localparam logic RST_ROLE = 1'b0;
    localparam logic [1:0] RST_DUTY = 2'h0;
    localparam logic RST_CMP = 1'b0;
    localparam logic RST_GIE = 1'b0;

    // External interrupt edge codes
    localparam logic [1:0] EDGE_RESERVED = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // One-cycle event pulses from the timers, detector and watchdog
    typedef struct packed {
        logic watchdog_timeout;
        logic low_voltage;
        logic timer1_underflow;
        logic timer0_overflow;
    } rps_events_t;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } rps_bus_state_t;

endpackage

// ==== verification/rps_periph_model.sv ====
// Stand-in for the timers, detector and watchdog that feed the register slice
`timescale 1ns/1ps
`default_nettype none
module rps_periph_model
    import rps_pkg::*;
(
    input wire logic mclk,           // Core clock
    input wire logic reset,          // Asynchronous reset, active high
    input wire logic [3:0] fire,     // Event requests from the bench, one cycle each
    input wire logic [9:0] count_in, // Value the running Timer1 count should show
    output rps_events_t events,      // One-cycle event pulses
    output logic [9:0] timer1_count  // Running Timer1 count
);
    // Registered so pulses and count change only just after an edge, as real logic would
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            events <= rps_events_t'(4'h0);
            timer1_count <= 10'h000;
        end else begin
            events <= rps_events_t'(fire);
            timer1_count <= count_in;
        end
    end
endmodule // rps_periph_model
`default_nettype wire

// ==== verification/rps_sfr_bank_tb.sv ====
// Self-checking bench for the upper register slice
`timescale 1ns/1ps
`default_nettype none
module rps_sfr_bank_tb
    import rps_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, pc_load = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, irq, ext_pin_role_select, timer1_reload_write, comparator_enable;
    logic [5:0] port_pins = 6'h00, pin_wake_enable, pull_high_enable_n;
    logic [3:0] pull_low_enable_n, fire = 4'h0;
    logic [2:0] pc_high;
    logic [1:0] timer1_upper_bits, pwm1_duty_upper, pwm2_duty_upper, pwm3_duty_upper;
    logic [9:0] timer1_count, cnt = 10'h000;
    rps_events_t events;
    logic [7:0] d, q;
    logic e;
    int checks = 0;
    int n_fail = 0;
    int n_reload = 0;

    // Register table: index, readable bits, reset value, bits visible at output ports
    localparam logic [4:0] IDX [11] = '{IDX_WAKE, IDX_PCHB, IDX_PULL_LOW, IDX_PULL_HIGH,
        IDX_INT_EN, IDX_INT_FLAGS, IDX_EDGE, IDX_TMR_HIGH, IDX_ANALOG, IDX_PWM3_HIGH, IDX_IRQ_CTRL};
    localparam logic [7:0] RMASK [11] = '{8'h3f, 8'h07, 8'hf0, 8'h3f, 8'h5f, 8'h5f, 8'h13,
        8'h3f, 8'h80, 8'h03, 8'h01};
    localparam logic [7:0] RST [11] = '{8'h3f, 8'h00, 8'hf0, 8'h3f, 8'h00, 8'h00, 8'h01,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] OMASK [11] = '{8'h3f, 8'h00, 8'hf0, 8'h3f, 8'h00, 8'h00, 8'h10,
        8'h3f, 8'h80, 8'h03, 8'h00};
    localparam logic [7:0] FBIT [4] = '{8'h01, 8'h08, 8'h10, 8'h40};

    always #10 mclk = ~mclk;

    // Counts reload pulses so every timer high write can be matched to exactly one
    always @(negedge mclk) begin
        if (timer1_reload_write === 1'b1) begin
            n_reload++;
        end
    end

    rps_periph_model u_periph (.mclk(mclk), .reset(reset), .fire(fire), .count_in(cnt),
        .events(events), .timer1_count(timer1_count));

    rps_sfr_bank u_dut (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_pins(port_pins), .events(events),
        .timer1_count(timer1_count), .pc_load(pc_load), .irq(irq),
        .pin_wake_enable(pin_wake_enable), .pull_low_enable_n(pull_low_enable_n),
        .pull_high_enable_n(pull_high_enable_n), .pc_high(pc_high),
        .ext_pin_role_select(ext_pin_role_select), .timer1_upper_bits(timer1_upper_bits),
        .timer1_reload_write(timer1_reload_write), .pwm1_duty_upper(pwm1_duty_upper),
        .pwm2_duty_upper(pwm2_duty_upper), .pwm3_duty_upper(pwm3_duty_upper),
        .comparator_enable(comparator_enable));

    // Port view of a register, laid out like its bits
    function automatic logic [7:0] outv(input int i);
        case (i)
            0: outv = {2'h0, pin_wake_enable};
            2: outv = {pull_low_enable_n, 4'h0};
            3: outv = {2'h0, pull_high_enable_n};
            6: outv = {3'h0, ext_pin_role_select, 4'h0};
            7: outv = {2'h0, timer1_upper_bits, pwm2_duty_upper, pwm1_duty_upper};
            8: outv = {comparator_enable, 7'h00};
            9: outv = {6'h00, pwm3_duty_upper};
            default: outv = 8'h00;
        endcase
    endfunction

    // Read-back value: timer bits show the live count, not what was written
    function automatic logic [7:0] expv(input int i, input logic [7:0] v);
        expv = v & RMASK[i];
        if (i == 7) begin
            expv = {2'h0, cnt[9:8], v[3:0]};
        end
    endfunction

    task automatic stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One classic cycle; the wait for ack is bounded so a dead slave ends the run
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] v,
                       output logic [7:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, v};
        do begin
            @(negedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (wb_ack_o !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t bus timeout", $time);
            stop_test();
        end
        @(posedge mclk);
        r = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] v);
        logic [7:0] r;
        bus(1'b1, {1'b0, idx, 2'b00}, v, r);
    endtask

    task automatic chk(input logic [4:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        bus(1'b0, {1'b0, idx, 2'b00}, 8'h00, r);
        cmp(r, exp, "register read");
    endtask

    task automatic irqc(input logic exp);
        @(negedge mclk);
        cmp({7'h0, irq}, {7'h0, exp}, "irq level");
    endtask

    initial begin
        void'($urandom(96));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        // Reset values, at the registers and at the ports
        for (int i = 0; i < 11; i++) begin
            chk(IDX[i], RST[i]);
            cmp(outv(i) & OMASK[i], RST[i] & OMASK[i], "reset port");
        end
        // All ones, all zeros, then random data through every plain register
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 11; i++) begin
                if (i == 5) continue;
                d = (r == 0) ? 8'hff : (r == 1) ? 8'h00 : 8'($urandom());
                cnt <= 10'($urandom());
                wr(IDX[i], d);
                chk(IDX[i], expv(i, d));
                cmp(outv(i) & OMASK[i], d & OMASK[i], "port");
            end
        end
        cmp(8'(n_reload), 8'h05, "reload pulses");
        // Buffer writes alone must not reach the PC high bits
        cmp({5'h0, pc_high}, 8'h00, "pc high before load");
        wr(IDX_PCHB, 8'h05);
        pc_load <= 1'b1;
        @(posedge mclk);
        pc_load <= 1'b0;
        repeat (2) @(negedge mclk);
        cmp({5'h0, pc_high}, 8'h05, "pc high after load");
        // Unmapped and misaligned accesses are answered but change nothing
        wr(IDX_WAKE, 8'h2a);
        bus(1'b1, 8'h25, 8'h00, q);
        bus(1'b1, 8'h84, 8'hff, q);
        bus(1'b0, 8'h84, 8'h00, q);
        cmp(q, 8'h00, "unmapped read");
        chk(IDX_WAKE, 8'h2a);
        // Each of the four peripheral events: masked read, latch, gating, clear by writing zero
        wr(IDX_IRQ_CTRL, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(IDX_INT_EN, 8'h00);
            wr(IDX_INT_FLAGS, 8'h00);
            fire <= 4'h1 << k;
            @(posedge mclk);
            fire <= 4'h0;
            irqc(1'b0);
            chk(IDX_INT_FLAGS, 8'h00);
            wr(IDX_INT_EN, FBIT[k]);
            wr(IDX_INT_FLAGS, 8'hff);
            chk(IDX_INT_FLAGS, FBIT[k]);
            irqc(1'b1);
            wr(IDX_IRQ_CTRL, 8'h00);
            irqc(1'b0);
            wr(IDX_IRQ_CTRL, 8'h01);
            irqc(1'b1);
            wr(IDX_INT_FLAGS, ~FBIT[k]);
            chk(IDX_INT_FLAGS, 8'h00);
            irqc(1'b0);
        end
        // Pin change counts only where wake is enabled
        wr(IDX_INT_EN, 8'h06);
        wr(IDX_WAKE, 8'h02);
        wr(IDX_EDGE, 8'h01);
        wr(IDX_INT_FLAGS, 8'h00);
        port_pins <= 6'h04;
        repeat (6) @(posedge mclk);
        chk(IDX_INT_FLAGS, 8'h00);
        port_pins <= 6'h06;
        repeat (6) @(posedge mclk);
        chk(IDX_INT_FLAGS, 8'h02);
        // Every edge code with the pin as interrupt input, then the pin left as plain I/O
        wr(IDX_WAKE, 8'h00);
        for (int c = 0; c < 5; c++) begin
            wr(IDX_EDGE, (c == 4) ? 8'h03 : (8'h10 | 8'(c)));
            for (int v = 1; v >= 0; v--) begin
                wr(IDX_INT_FLAGS, 8'h00);
                port_pins <= {port_pins[5:1], v[0]};
                e = (c < 4) && ((v == 1) ? c[0] : c[1]);
                repeat (6) @(posedge mclk);
                chk(IDX_INT_FLAGS, {5'h0, e, 2'h0});
            end
        end
        stop_test();
    end
endmodule // rps_sfr_bank_tb
`default_nettype wire
